// ==== rtl/hfvc_top.sv ====
// Hydraulic fan valve controller: temperature based proportional drive and reverse sequencing.
// Assumes all inputs come from logic on core_clk; registers reached by a plain strobe port.
// Function
// - Up to four temperature channels feed the fan speed command.
// - Every logical input has an inversion bit, default off.
// - Proportional drive: zero means fan stopped, full scale means maximum speed.
// - Direction drive: 0 normal rotation, 1 reverse rotation.
// - Regulation only with direction 0; controlling temperature chosen by comparison.
// - Chosen temperature scaled into speed range and driven on proportional output.
// - Asserted reverse input enters reverse mode for dust blow-off.
// - Reverse mode holds both drives at full unless stop input is asserted; regulation suspended.
// - Each mode change zeroes proportional drive before direction toggles.
// - Asserted stop input forces proportional drive to zero.
// - Each channel selects any source output; default unconnected.
// - Full-scale temperature maps signal 1.0, default 120.0 C.
// - Zero-scale temperature maps signal 0.0, default 20.0 C.
// - Max-speed 100.0 and min-speed 80.0 defaults per channel.
// - Priority channel controls while all others stay below max-speed temperature.
`include "hfvc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module hfvc_top (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire hfvc_pkg::hfvc_src_t   src_bus,
   input  wire logic                  reverse_req,
   input  wire logic                  stop_req,
   input  wire hfvc_pkg::hfvc_bus_t   bus,
   output logic [31:0]                rdata,
   output logic [15:0]                proportional_valve_drive,
   output logic                       direction_valve_drive
);

   hfvc_pkg::hfvc_state_t st_ff;
   hfvc_pkg::hfvc_state_t nxt_st;

   logic [3:0][15:0]        chan_sig;
   logic [3:0]              chan_on;
   logic signed [3:0][17:0] chan_temp;
   logic [3:0][15:0]        chan_spd;
   logic [3:0]              chan_hot;
   logic                    rev_act;
   logic                    stop_act;
   logic [15:0]             reg_spd;
   logic [2:0]              reg_sel;
   logic                    prio_ok;

   // Signal 0..1.0 onto the zero-scale .. full-scale temperature span
   function automatic logic signed [17:0] to_temp(input logic [15:0] s,
                                                  input hfvc_pkg::hfvc_cal_t c);
      logic signed [17:0] span;
      logic signed [34:0] prod;
      span = 18'(c.tmax) - 18'(c.tmin);
      prod = $signed({1'b0, s}) * span;
      to_temp = 18'(c.tmin) + 18'(prod >>> 16);
   endfunction

   // Clamped linear map of temperature onto min..max speed
   function automatic logic [15:0] to_speed(input logic signed [17:0] t,
                                            input hfvc_pkg::hfvc_cal_t c,
                                            input logic [15:0] smin,
                                            input logic [15:0] smax);
      logic signed [17:0] num;
      logic signed [17:0] den;
      logic signed [35:0] prod;
      logic signed [35:0] quo;
      num = t - 18'(c.tlow);
      den = 18'(c.thigh) - 18'(c.tlow);
      prod = num * $signed({2'b00, smax - smin});
      quo = (den > 0) ? prod / 36'(den) : 36'sd0;
      if (t <= 18'(c.tlow)) begin
         to_speed = smin;
      end else if (t >= 18'(c.thigh)) begin
         to_speed = smax;
      end else begin
         to_speed = smin + quo[15:0];
      end
   endfunction

   assign rev_act  = reverse_req ^ st_ff.rev_inv;
   assign stop_act = stop_req ^ st_ff.stop_inv;

   // Per-channel source pick, inversion, temperature and speed demand
   always_comb begin
      for (int i = 0; i < `HFVC_NUM_CH; i++) begin
         chan_on[i]  = (st_ff.src[i] != 4'h0) &&
                       (st_ff.src[i] <= 4'(`HFVC_NUM_SRC));
         chan_sig[i] = chan_on[i] ? src_bus[3'(st_ff.src[i] - 4'h1)] : 16'h0000;
         if (st_ff.tinv[i]) begin
            chan_sig[i] = ~chan_sig[i];
         end
         chan_temp[i] = to_temp(chan_sig[i], st_ff.cal[i]);
         chan_spd[i]  = to_speed(chan_temp[i], st_ff.cal[i],
                                 st_ff.spd_min, st_ff.spd_max);
         // Element select of a packed array is unsigned; keep the compare signed
         chan_hot[i]  = chan_on[i] &&
                        ($signed(chan_temp[i]) >= 18'(st_ff.cal[i].thigh));
      end
   end

   // Controlling channel: priority when others are cool, else highest demand
   always_comb begin
      prio_ok = (st_ff.prio >= 3'h1) && (st_ff.prio <= 3'h4) &&
                chan_on[2'(st_ff.prio - 3'h1)];
      for (int i = 0; i < `HFVC_NUM_CH; i++) begin
         if (i != int'(st_ff.prio) - 1 && chan_hot[i]) begin
            prio_ok = 1'b0;
         end
      end
      reg_sel = 3'h0;
      reg_spd = `HFVC_ZERO;
      if (prio_ok) begin
         reg_sel = st_ff.prio;
         reg_spd = chan_spd[2'(st_ff.prio - 3'h1)];
      end else begin
         for (int i = 0; i < `HFVC_NUM_CH; i++) begin
            if (chan_on[i] && (reg_sel == 3'h0 || chan_spd[i] > reg_spd)) begin
               reg_sel = 3'(i + 1);
               reg_spd = chan_spd[i];
            end
         end
      end
   end

   // Next state: register port, mode sequencer, output drives
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rdata = 32'h0000_0000;

      if (bus.wr) begin
         unique case (bus.addr)
            `HFVC_REG_CTRL: begin
               nxt_st.tinv     = bus.wdata[`HFVC_CTRL_TINV_LSB +: 4];
               nxt_st.rev_inv  = bus.wdata[`HFVC_CTRL_REVINV];
               nxt_st.stop_inv = bus.wdata[`HFVC_CTRL_STPINV];
               nxt_st.prio     = bus.wdata[`HFVC_CTRL_PRIO_LSB +: 3];
            end
            `HFVC_REG_SRC:     nxt_st.src     = bus.wdata[15:0];
            `HFVC_REG_SPD_MIN: nxt_st.spd_min = bus.wdata[15:0];
            `HFVC_REG_SPD_MAX: nxt_st.spd_max = bus.wdata[15:0];
            default: begin
               if (bus.addr >= `HFVC_REG_CAL_BASE && bus.addr <= `HFVC_REG_CAL_END &&
                   bus.addr[1:0] == 2'b00) begin
                  unique case (bus.addr[3:2])
                     2'h0: nxt_st.cal[bus.addr[5:4] - 2'h2].tmax  = bus.wdata[15:0];
                     2'h1: nxt_st.cal[bus.addr[5:4] - 2'h2].thigh = bus.wdata[15:0];
                     2'h2: nxt_st.cal[bus.addr[5:4] - 2'h2].tlow  = bus.wdata[15:0];
                     2'h3: nxt_st.cal[bus.addr[5:4] - 2'h2].tmin  = bus.wdata[15:0];
                  endcase
               end
            end
         endcase
      end

      if (bus.rd) begin
         unique case (bus.addr)
            `HFVC_REG_CTRL: begin
               nxt_st.rdata = {21'h0, st_ff.prio, 2'h0, st_ff.stop_inv,
                               st_ff.rev_inv, st_ff.tinv};
            end
            `HFVC_REG_SRC:     nxt_st.rdata = {16'h0, st_ff.src};
            `HFVC_REG_SPD_MIN: nxt_st.rdata = {16'h0, st_ff.spd_min};
            `HFVC_REG_SPD_MAX: nxt_st.rdata = {16'h0, st_ff.spd_max};
            `HFVC_REG_STATUS: begin
               nxt_st.rdata = {st_ff.prop, 7'h0, stop_act, rev_act, st_ff.sel,
                               st_ff.dir, st_ff.mode};
            end
            default: begin
               if (bus.addr >= `HFVC_REG_CAL_BASE && bus.addr <= `HFVC_REG_CAL_END &&
                   bus.addr[1:0] == 2'b00) begin
                  unique case (bus.addr[3:2])
                     2'h0: nxt_st.rdata = {16'h0, st_ff.cal[bus.addr[5:4] - 2'h2].tmax};
                     2'h1: nxt_st.rdata = {16'h0, st_ff.cal[bus.addr[5:4] - 2'h2].thigh};
                     2'h2: nxt_st.rdata = {16'h0, st_ff.cal[bus.addr[5:4] - 2'h2].tlow};
                     2'h3: nxt_st.rdata = {16'h0, st_ff.cal[bus.addr[5:4] - 2'h2].tmin};
                  endcase
               end
            end
         endcase
      end

      nxt_st.cnt = `HFVC_ZERO;
      nxt_st.sel = 3'h0;
      unique case (st_ff.mode)
         hfvc_pkg::HFVC_DIRECT: begin
            nxt_st.dir  = 1'b0;
            nxt_st.sel  = reg_sel;
            nxt_st.prop = reg_spd;
            if (rev_act) begin
               nxt_st.mode = hfvc_pkg::HFVC_DRAIN_TO_REV;
               nxt_st.prop = `HFVC_ZERO;
            end
         end
         hfvc_pkg::HFVC_DRAIN_TO_REV: begin
            nxt_st.prop = `HFVC_ZERO;
            nxt_st.cnt  = st_ff.cnt + 16'h0001;
            if (!rev_act) begin
               nxt_st.mode = hfvc_pkg::HFVC_DIRECT;
            end else if (st_ff.cnt >= 16'(`HFVC_SETTLE_CYC - 1)) begin
               nxt_st.mode = hfvc_pkg::HFVC_REVERSE;
               nxt_st.dir  = 1'b1;
            end
         end
         hfvc_pkg::HFVC_REVERSE: begin
            nxt_st.prop = `HFVC_FULL_SCALE;
            if (!rev_act) begin
               nxt_st.mode = hfvc_pkg::HFVC_DRAIN_TO_DIR;
               nxt_st.prop = `HFVC_ZERO;
            end
         end
         hfvc_pkg::HFVC_DRAIN_TO_DIR: begin
            nxt_st.prop = `HFVC_ZERO;
            nxt_st.cnt  = st_ff.cnt + 16'h0001;
            if (rev_act) begin
               nxt_st.mode = hfvc_pkg::HFVC_REVERSE;
            end else if (st_ff.cnt >= 16'(`HFVC_SETTLE_CYC - 1)) begin
               nxt_st.mode = hfvc_pkg::HFVC_DIRECT;
               nxt_st.dir  = 1'b0;
            end
         end
         default: begin
            nxt_st.mode = hfvc_pkg::HFVC_DRAIN_TO_DIR;
            nxt_st.prop = `HFVC_ZERO;
         end
      endcase

      if (stop_act) begin
         nxt_st.prop = `HFVC_ZERO;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff.mode     <= hfvc_pkg::HFVC_DIRECT;
         st_ff.cnt      <= `HFVC_ZERO;
         st_ff.prop     <= `HFVC_ZERO;
         st_ff.dir      <= 1'b0;
         st_ff.sel      <= 3'h0;
         st_ff.rdata    <= 32'h0000_0000;
         st_ff.tinv     <= 4'h0;
         st_ff.rev_inv  <= 1'b0;
         st_ff.stop_inv <= 1'b0;
         st_ff.prio     <= 3'h0;
         st_ff.src      <= 16'h0000;
         st_ff.spd_min  <= `HFVC_RST_SPD_MIN;
         st_ff.spd_max  <= `HFVC_RST_SPD_MAX;
         for (int i = 0; i < `HFVC_NUM_CH; i++) begin
            st_ff.cal[i] <= {`HFVC_RST_TMAX, `HFVC_RST_THIGH,
                             `HFVC_RST_TLOW, `HFVC_RST_TMIN};
         end
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata                    = st_ff.rdata;
   assign proportional_valve_drive = st_ff.prop;
   assign direction_valve_drive    = st_ff.dir;

endmodule // hfvc_top

`default_nettype wire

// ==== rtl/hfvc_cfg.svh ====
// Constants of the hydraulic fan valve controller: offsets, fields, resets, timing.
// Assumes a 100 MHz core clock and a byte-addressed word register port.
`ifndef HFVC_CFG_SVH
`define HFVC_CFG_SVH

`define HFVC_CLK_PERIOD_NS  10
// Least time the proportional drive stays at zero before the direction flips
`define HFVC_SETTLE_NS      1000
`define HFVC_SETTLE_CYC     ((`HFVC_SETTLE_NS + `HFVC_CLK_PERIOD_NS - 1) / `HFVC_CLK_PERIOD_NS)

`define HFVC_NUM_CH         4
`define HFVC_NUM_SRC        8
`define HFVC_ADDR_W         8

// Register byte offsets
`define HFVC_REG_CTRL       8'h00
`define HFVC_REG_SRC        8'h04
`define HFVC_REG_SPD_MIN    8'h08
`define HFVC_REG_SPD_MAX    8'h0C
`define HFVC_REG_STATUS     8'h10
`define HFVC_REG_CAL_BASE   8'h20
`define HFVC_REG_CAL_END    8'h5C

// CTRL fields
`define HFVC_CTRL_TINV_LSB  0
`define HFVC_CTRL_REVINV    4
`define HFVC_CTRL_STPINV    5
`define HFVC_CTRL_PRIO_LSB  8

// Reset values; temperatures in tenths of a degree C, speeds as 16-bit fractions
`define HFVC_RST_TMAX       16'sh04B0
`define HFVC_RST_THIGH      16'sh03E8
`define HFVC_RST_TLOW       16'sh0320
`define HFVC_RST_TMIN       16'sh00C8
`define HFVC_RST_SPD_MIN    16'h1999
`define HFVC_RST_SPD_MAX    16'hFFFF
`define HFVC_FULL_SCALE     16'hFFFF
`define HFVC_ZERO           16'h0000

`endif

// ==== rtl/hfvc_pkg.sv ====
// Types of the hydraulic fan valve controller.
// Assumes hfvc_cfg.svh is compiled alongside.
package hfvc_pkg;

   typedef enum logic [2:0] {
      HFVC_DIRECT,
      HFVC_DRAIN_TO_REV,
      HFVC_REVERSE,
      HFVC_DRAIN_TO_DIR
   } hfvc_mode_t;

   typedef struct packed {
      logic signed [15:0] tmax;
      logic signed [15:0] thigh;
      logic signed [15:0] tlow;
      logic signed [15:0] tmin;
   } hfvc_cal_t;

   typedef logic [7:0][15:0] hfvc_src_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } hfvc_bus_t;

   typedef struct packed {
      hfvc_mode_t         mode;
      logic [15:0]        cnt;
      logic [15:0]        prop;
      logic               dir;
      logic [2:0]         sel;
      logic [31:0]        rdata;
      logic [3:0]         tinv;
      logic               rev_inv;
      logic               stop_inv;
      logic [2:0]         prio;
      logic [3:0][3:0]    src;
      logic [15:0]        spd_min;
      logic [15:0]        spd_max;
      hfvc_cal_t [3:0]    cal;
   } hfvc_state_t;

endpackage

// ==== verification/hfvc_checker.sv ====
// Checker of the fan valve controller ports, bound into hfvc_top.
// Assumes reverse and stop inversions stay off around every direction change.
`include "hfvc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module hfvc_checker (
   input wire logic                core_clk,
   input wire logic                rst,
   input wire hfvc_pkg::hfvc_src_t src_bus,
   input wire logic                reverse_req,
   input wire logic                stop_req,
   input wire hfvc_pkg::hfvc_bus_t bus,
   input wire logic [31:0]         rdata,
   input wire logic [15:0]         proportional_valve_drive,
   input wire logic                direction_valve_drive
);
   localparam int SETTLE = `HFVC_SETTLE_CYC;
   logic [15:0] pv;
   logic        dv;
   logic [15:0] zc_ff;
   logic [15:0] nxt_zc;
   assign pv = proportional_valve_drive;
   assign dv = direction_valve_drive;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Run length of zero proportional drive, saturating
   always_comb begin
      nxt_zc = (pv != 16'h0000) ? 16'h0000 : zc_ff + {15'h0000, zc_ff != 16'hFFFF};
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) zc_ff <= 16'h0000;
      else zc_ff <= nxt_zc;
   end
   a_stop_zero: assert property (stop_req |=> pv == 16'h0000)
      else $error("proportional drive not zero after stop");
   a_settle_first: assert property ($changed(dv) |-> zc_ff >= SETTLE - 1)
      else $error("direction changed without settled zero drive");
   a_rev_full: assert property ($rose(dv) && reverse_req && !stop_req |=> pv == 16'hFFFF)
      else $error("reverse mode drive not full");
   a_rev_enter: assert property ($rose(reverse_req) && !dv |=> pv == 16'h0000)
      else $error("drive not zeroed on reverse request");
   a_rev_leave: assert property ($fell(reverse_req) && dv |=> pv == 16'h0000)
      else $error("drive not zeroed on reverse release");
   a_dir_cause: assert property ($rose(dv) |-> $past(reverse_req))
      else $error("direction rose without reverse request");
   a_dir_back: assert property ($fell(dv) |-> !$past(reverse_req))
      else $error("direction fell with reverse request held");
   a_no_reg_rev: assert property (dv |-> pv == 16'h0000 || pv == 16'hFFFF)
      else $error("regulated drive while reversed");
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h00000000)
      else $error("read data outside read answer cycle");
endmodule // hfvc_checker
bind hfvc_top hfvc_checker chk_u (
   .core_clk(core_clk), .rst(rst), .src_bus(src_bus), .reverse_req(reverse_req),
   .stop_req(stop_req), .bus(bus), .rdata(rdata),
   .proportional_valve_drive(proportional_valve_drive),
   .direction_valve_drive(direction_valve_drive));
`default_nettype wire

// ==== verification/hfvc_valve_model.sv ====
// Model of the proportional and reversing valve pair driven by the controller.
// Assumes drives are registered on core_clk; the valves themselves never reset.
`timescale 1ns/1ps
`default_nettype none
module hfvc_valve_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [15:0] prop,
   input  wire logic        dir,
   output logic [7:0]       flips,
   output logic             bad
);
   logic        dir_l;
   logic [15:0] prop_l;
   initial begin
      flips = 8'h00;
      bad = 1'b0;
   end
   // Reversing spool may only shift with the motor unloaded
   always @(posedge core_clk) begin
      dir_l <= dir;
      prop_l <= prop;
      if (!rst && dir_l !== dir) begin
         flips <= flips + 8'h01;
         if (prop_l !== 16'h0000 || prop !== 16'h0000) bad <= 1'b1;
      end
   end
endmodule // hfvc_valve_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench of the fan valve controller with the valve pair model.
// Assumes hfvc_pkg and hfvc_cfg.svh are compiled first.
`include "hfvc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] v;} hfvc_exp_t;
   localparam logic [31:0] ALL_M = 32'hFFFFFFFF;
   logic                core_clk;
   logic                rst;
   logic                reverse_req;
   logic                stop_req;
   hfvc_pkg::hfvc_src_t src_bus;
   hfvc_pkg::hfvc_bus_t bus;
   logic [31:0]         rdata;
   logic [15:0]         prop;
   logic                dir;
   logic                bad;
   logic                rd_q = 1'b0;
   logic [7:0]          flips;
   hfvc_exp_t           exp_q[$];
   hfvc_exp_t           e;
   int                  fail_count = 0;
   int                  checked = 0;
   int                  cyc = 0;
   hfvc_top dut_u (.core_clk(core_clk), .rst(rst), .src_bus(src_bus),
      .reverse_req(reverse_req), .stop_req(stop_req), .bus(bus), .rdata(rdata),
      .proportional_valve_drive(prop), .direction_valve_drive(dir));
   hfvc_valve_model valve_u (.core_clk(core_clk), .rst(rst), .prop(prop), .dir(dir),
      .flips(flips), .bad(bad));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic complete_run();
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus <= {a, d, 2'b10};
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      exp_q.push_back('{a, m, v});
      bus <= {a, 32'h00000000, 2'b01};
      @(posedge core_clk);
   endtask
   task automatic nop(input int n);
      bus <= '0;
      repeat (n) @(posedge core_clk);
   endtask
   function automatic int tmp(input logic [15:0] v);
      int s;
      s = v;
      return `HFVC_RST_TMIN + ((s * (`HFVC_RST_TMAX - `HFVC_RST_TMIN)) >>> 16);
   endfunction
   function automatic logic [15:0] spd(input int t);
      int r;
      if (t <= `HFVC_RST_TLOW) r = `HFVC_RST_SPD_MIN;
      else if (t >= `HFVC_RST_THIGH) r = `HFVC_RST_SPD_MAX;
      else r = `HFVC_RST_SPD_MIN + (t - `HFVC_RST_TLOW)
         * (`HFVC_RST_SPD_MAX - `HFVC_RST_SPD_MIN) / (`HFVC_RST_THIGH - `HFVC_RST_TLOW);
      return r[15:0];
   endfunction
   // Read answers arrive one cycle after the strobe
   always @(posedge core_clk) begin
      rd_q <= bus.rd;
      cyc <= cyc + 1;
      if (rd_q === 1'b1) begin
         checked++;
         e = exp_q.pop_front();
         if ((rdata & e.m) !== (e.v & e.m)) begin
            fail_count++;
            $display("CHECK FAILED rdata at %h exp %h seen %h", e.a, e.v & e.m, rdata & e.m);
         end
      end
      if (cyc == 3000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      logic [15:0]         a;
      logic [15:0]         b;
      logic [15:0]         ex;
      logic [31:0]         d;
      logic [7:0]          o;
      logic [2:0]          sel;
      logic [3:0]          iv;
      int                  p;
      hfvc_pkg::hfvc_src_t r;
      rst = 1'b1;
      reverse_req = 1'b0;
      stop_req = 1'b0;
      bus = '0;
      src_bus = '0;
      void'($urandom(32'hA1663BA4));
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'h00, ALL_M, 32'h00000000);
      rd(8'h04, ALL_M, 32'h00000000);
      rd(8'h08, ALL_M, 32'h00001999);
      rd(8'h0C, ALL_M, 32'h0000FFFF);
      rd(8'h10, 32'hFFFF007F, 32'h00000000);
      rd(8'h14, ALL_M, 32'h00000000);
      for (int c = 0; c < 4; c++) begin
         o = 8'h20 + 8'(c * 16);
         rd(o, ALL_M, 32'h000004B0);
         rd(o + 8'h04, ALL_M, 32'h000003E8);
         rd(o + 8'h08, ALL_M, 32'h00000320);
         rd(o + 8'h0C, ALL_M, 32'h000000C8);
      end
      wr(8'h04, 32'h00000021);
      for (int i = 0; i < 12; i++) begin
         r = {$urandom, $urandom, $urandom, $urandom};
         if (i == 0) r[1:0] = {16'hFFFF, 16'h0000};
         iv = 4'($urandom % 4);
         p = i % 3;
         a = iv[0] ? ~r[0] : r[0];
         b = iv[1] ? ~r[1] : r[1];
         sel = 3'h1;
         ex = spd(tmp(a));
         if ((p == 2 && tmp(a) < `HFVC_RST_THIGH) ||
             ((p != 1 || tmp(b) >= `HFVC_RST_THIGH) && spd(tmp(b)) > ex)) begin
            sel = 3'h2;
            ex = spd(tmp(b));
         end
         src_bus <= r;
         wr(8'h00, {21'h000000, 3'(p), 4'h0, iv});
         nop(2);
         rd(8'h10, 32'hFFFF007F, {ex, 9'h000, sel, 4'h0});
      end
      // Inverted reverse and stop act while both inputs stay low
      wr(8'h00, 32'h00000030);
      nop(2);
      rd(8'h10, 32'hFFFF018F, 32'h00000181);
      wr(8'h00, 32'h00000000);
      d = $urandom;
      wr(8'h08, d);
      wr(8'h0C, ~d);
      wr(8'h5C, d ^ 32'h0000A5A5);
      rd(8'h08, ALL_M, {16'h0000, d[15:0]});
      rd(8'h0C, ALL_M, {16'h0000, ~d[15:0]});
      rd(8'h5C, ALL_M, {16'h0000, d[15:0] ^ 16'hA5A5});
      stop_req <= 1'b1;
      nop(2);
      rd(8'h10, 32'hFFFF0100, 32'h00000100);
      stop_req <= 1'b0;
      reverse_req <= 1'b1;
      nop(3);
      reverse_req <= 1'b0;
      nop(3);
      rd(8'h10, 32'h0000000F, 32'h00000000);
      reverse_req <= 1'b1;
      nop(2);
      rd(8'h10, 32'hFFFF000F, 32'h00000001);
      nop(110);
      rd(8'h10, 32'hFFFF008F, 32'hFFFF008A);
      stop_req <= 1'b1;
      nop(2);
      rd(8'h10, 32'hFFFF010F, 32'h0000010A);
      stop_req <= 1'b0;
      nop(2);
      wr(8'h10, ALL_M);
      rd(8'h10, 32'hFFFF008F, 32'hFFFF008A);
      reverse_req <= 1'b0;
      nop(2);
      rd(8'h10, 32'hFFFF000F, 32'h0000000B);
      nop(110);
      rd(8'h10, 32'h0000000F, 32'h00000000);
      nop(2);
      rst <= 1'b1;
      nop(2);
      rst <= 1'b0;
      rd(8'h00, ALL_M, 32'h00000000);
      rd(8'h04, ALL_M, 32'h00000000);
      rd(8'h08, ALL_M, 32'h00001999);
      rd(8'h0C, ALL_M, 32'h0000FFFF);
      rd(8'h5C, ALL_M, 32'h000000C8);
      nop(3);
      checked += 2;
      if (flips !== 8'h02) begin
         fail_count++;
         $display("CHECK FAILED direction flips exp 02 seen %h", flips);
      end
      if (bad !== 1'b0) begin
         fail_count++;
         $display("CHECK FAILED loaded direction change exp 0 seen %b", bad);
      end
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
